// *** design/pie_enable_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pie_defs.svh"

module pie_enable_bank #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    clkEn,
    input  wire logic [`PIE_ADDR_W-1:0]  regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWrStb,
    input  wire logic                    regRdStb,
    output logic      [7:0]              regRdData,
    input  wire logic                    globalPeripheralIrqGate,
    input  wire logic [7:0]              eventTwo,
    input  wire logic [7:0]              eventThree,
    input  wire logic [7:0]              eventFour,
    output logic                         irqRequest
);

    pie_pkg::pie_state_type state_r;
    pie_pkg::pie_state_type state_nxt;

    // Mask of register three/four bits present in this variant
    localparam logic [7:0] MASK_THREE = LARGE_VARIANT ? `PIE_MASK_THREE : 8'h00;
    localparam logic [7:0] MASK_FOUR  = LARGE_VARIANT ? `PIE_MASK_FOUR  : 8'h00;

    // Flag update: hardware set wins over software clear
    function automatic logic [7:0] flag_next(
        input logic [7:0] cur,
        input logic [7:0] evt,
        input logic [7:0] mask,
        input logic       wr,
        input logic [7:0] wdat
    );
        logic [7:0] base;
        base = wr ? wdat : cur;
        return (base | evt) & mask;
    endfunction : flag_next

    logic wrTwo;
    logic wrThree;
    logic wrFour;
    logic wrFlagTwo;
    logic wrFlagThree;
    logic wrFlagFour;

    // Write decode
    assign wrTwo       = regWrStb && regAddr == `PIE_IDX_ENABLE_TWO;
    assign wrThree     = regWrStb && regAddr == `PIE_IDX_ENABLE_THREE;
    assign wrFour      = regWrStb && regAddr == `PIE_IDX_ENABLE_FOUR;
    assign wrFlagTwo   = regWrStb && regAddr == `PIE_IDX_FLAG_TWO;
    assign wrFlagThree = regWrStb && regAddr == `PIE_IDX_FLAG_THREE;
    assign wrFlagFour  = regWrStb && regAddr == `PIE_IDX_FLAG_FOUR;

    // Read selects, one per mapped index
    logic rdSelEnTwo;
    logic rdSelEnThree;
    logic rdSelEnFour;
    logic rdSelFlagTwo;
    logic rdSelFlagThree;
    logic rdSelFlagFour;
    logic rdSelStatus;
    assign rdSelEnTwo     = regRdStb && regAddr == `PIE_IDX_ENABLE_TWO;
    assign rdSelEnThree   = regRdStb && regAddr == `PIE_IDX_ENABLE_THREE;
    assign rdSelEnFour    = regRdStb && regAddr == `PIE_IDX_ENABLE_FOUR;
    assign rdSelFlagTwo   = regRdStb && regAddr == `PIE_IDX_FLAG_TWO;
    assign rdSelFlagThree = regRdStb && regAddr == `PIE_IDX_FLAG_THREE;
    assign rdSelFlagFour  = regRdStb && regAddr == `PIE_IDX_FLAG_FOUR;
    assign rdSelStatus    = regRdStb && regAddr == `PIE_IDX_STATUS;

    // Oscillator fail, register two
    // A stale flag fires as soon as its enable is set
    logic oscFailEvent;
    logic oscFailIrqEnable;
    logic oscFailPending;
    logic oscFailReq;

    // Event in, gated request out
    assign oscFailEvent     = eventTwo[`PIE_BIT_OSC_FAIL];
    assign oscFailIrqEnable = state_r.enableTwo[`PIE_BIT_OSC_FAIL];
    assign oscFailPending   = state_r.flagTwo[`PIE_BIT_OSC_FAIL];
    assign oscFailReq       = oscFailPending && oscFailIrqEnable;

    // Comparator two, register two
    // Comparator edges may come in bursts; the flag keeps one
    logic cmpTwoEvent;
    logic comparatorTwoIrqEnable;
    logic cmpTwoPending;
    logic cmpTwoReq;

    // Event in, gated request out
    assign cmpTwoEvent            = eventTwo[`PIE_BIT_CMP_TWO];
    assign comparatorTwoIrqEnable = state_r.enableTwo[`PIE_BIT_CMP_TWO];
    assign cmpTwoPending          = state_r.flagTwo[`PIE_BIT_CMP_TWO];
    assign cmpTwoReq              = cmpTwoPending && comparatorTwoIrqEnable;

    // Comparator one, register two
    // Separate enable from comparator two
    logic cmpOneEvent;
    logic comparatorOneIrqEnable;
    logic cmpOnePending;
    logic cmpOneReq;

    // Event in, gated request out
    assign cmpOneEvent            = eventTwo[`PIE_BIT_CMP_ONE];
    assign comparatorOneIrqEnable = state_r.enableTwo[`PIE_BIT_CMP_ONE];
    assign cmpOnePending          = state_r.flagTwo[`PIE_BIT_CMP_ONE];
    assign cmpOneReq              = cmpOnePending && comparatorOneIrqEnable;

    // EEPROM write completion, register two
    // Raised once per finished write
    logic eeDoneEvent;
    logic eepromWriteDoneIrqEnable;
    logic eeDonePending;
    logic eeDoneReq;

    // Event in, gated request out
    assign eeDoneEvent              = eventTwo[`PIE_BIT_EE_DONE];
    assign eepromWriteDoneIrqEnable = state_r.enableTwo[`PIE_BIT_EE_DONE];
    assign eeDonePending            = state_r.flagTwo[`PIE_BIT_EE_DONE];
    assign eeDoneReq                = eeDonePending && eepromWriteDoneIrqEnable;

    // Serial port one collision, register two
    // Collision is latched even while masked
    logic serOneCollEvent;
    logic serialOneCollisionIrqEnable;
    logic serOneCollPending;
    logic serOneCollReq;

    // Event in, gated request out
    assign serOneCollEvent             = eventTwo[`PIE_BIT_SER1_COLL];
    assign serialOneCollisionIrqEnable = state_r.enableTwo[`PIE_BIT_SER1_COLL];
    assign serOneCollPending           = state_r.flagTwo[`PIE_BIT_SER1_COLL];
    assign serOneCollReq               = serOneCollPending && serialOneCollisionIrqEnable;

    // Capture unit two, register two
    // Lowest implemented bit of register two
    logic capTwoEvent;
    logic captureTwoIrqEnable;
    logic capTwoPending;
    logic capTwoReq;

    // Event in, gated request out
    assign capTwoEvent         = eventTwo[`PIE_BIT_CAP_TWO];
    assign captureTwoIrqEnable = state_r.enableTwo[`PIE_BIT_CAP_TWO];
    assign capTwoPending       = state_r.flagTwo[`PIE_BIT_CAP_TWO];
    assign capTwoReq           = capTwoPending && captureTwoIrqEnable;

    // Capture unit four, register three
    // Tied off with register three in the smaller variant
    logic capFourEvent;
    logic captureFourIrqEnable;
    logic capFourPending;
    logic capFourReq;

    // Event in, gated request out
    assign capFourEvent         = eventThree[`PIE_BIT_CAP_FOUR];
    assign captureFourIrqEnable = state_r.enableThree[`PIE_BIT_CAP_FOUR];
    assign capFourPending       = state_r.flagThree[`PIE_BIT_CAP_FOUR];
    assign capFourReq           = capFourPending && captureFourIrqEnable;

    // Capture unit three, register three
    // Tied off with register three in the smaller variant
    logic capThreeEvent;
    logic captureThreeIrqEnable;
    logic capThreePending;
    logic capThreeReq;

    // Event in, gated request out
    assign capThreeEvent         = eventThree[`PIE_BIT_CAP_THREE];
    assign captureThreeIrqEnable = state_r.enableThree[`PIE_BIT_CAP_THREE];
    assign capThreePending       = state_r.flagThree[`PIE_BIT_CAP_THREE];
    assign capThreeReq           = capThreePending && captureThreeIrqEnable;

    // Timer six period match, register three
    // Periodic source; a slow handler sees only one pending match
    logic tmrSixEvent;
    logic timerSixMatchIrqEnable;
    logic tmrSixPending;
    logic tmrSixReq;

    // Event in, gated request out
    assign tmrSixEvent            = eventThree[`PIE_BIT_TMR_SIX];
    assign timerSixMatchIrqEnable = state_r.enableThree[`PIE_BIT_TMR_SIX];
    assign tmrSixPending          = state_r.flagThree[`PIE_BIT_TMR_SIX];
    assign tmrSixReq              = tmrSixPending && timerSixMatchIrqEnable;

    // Timer four period match, register three
    // Periodic source; a slow handler sees only one pending match
    logic tmrFourEvent;
    logic timerFourMatchIrqEnable;
    logic tmrFourPending;
    logic tmrFourReq;

    // Event in, gated request out
    assign tmrFourEvent            = eventThree[`PIE_BIT_TMR_FOUR];
    assign timerFourMatchIrqEnable = state_r.enableThree[`PIE_BIT_TMR_FOUR];
    assign tmrFourPending          = state_r.flagThree[`PIE_BIT_TMR_FOUR];
    assign tmrFourReq              = tmrFourPending && timerFourMatchIrqEnable;

    // Serial port two collision, register four
    // Tied off with register four in the smaller variant
    logic serTwoCollEvent;
    logic serialTwoCollisionIrqEnable;
    logic serTwoCollPending;
    logic serTwoCollReq;

    // Event in, gated request out
    assign serTwoCollEvent             = eventFour[`PIE_BIT_SER2_COLL];
    assign serialTwoCollisionIrqEnable = state_r.enableFour[`PIE_BIT_SER2_COLL];
    assign serTwoCollPending           = state_r.flagFour[`PIE_BIT_SER2_COLL];
    assign serTwoCollReq               = serTwoCollPending && serialTwoCollisionIrqEnable;

    // Serial port two event, register four
    // Tied off with register four in the smaller variant
    logic serTwoEvtEvent;
    logic serialTwoEventIrqEnable;
    logic serTwoEvtPending;
    logic serTwoEvtReq;

    // Event in, gated request out
    assign serTwoEvtEvent          = eventFour[`PIE_BIT_SER2_EVENT];
    assign serialTwoEventIrqEnable = state_r.enableFour[`PIE_BIT_SER2_EVENT];
    assign serTwoEvtPending        = state_r.flagFour[`PIE_BIT_SER2_EVENT];
    assign serTwoEvtReq            = serTwoEvtPending && serialTwoEventIrqEnable;

    // Source events gathered back into register order
    logic [7:0] evtTwo;
    logic [7:0] evtThree;
    logic [7:0] evtFour;
    assign evtTwo   = {oscFailEvent, cmpTwoEvent, cmpOneEvent, eeDoneEvent,
                       serOneCollEvent, 2'h0, capTwoEvent};
    assign evtThree = {2'h0, capFourEvent, capThreeEvent, tmrSixEvent,
                       1'h0, tmrFourEvent, 1'h0};
    assign evtFour  = {6'h00, serTwoCollEvent, serTwoEvtEvent};

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        // Enable bits, one per source; unimplemented bits stay zero
        if (wrTwo) begin
            state_nxt.enableTwo[`PIE_BIT_OSC_FAIL]  = regWrData[`PIE_BIT_OSC_FAIL];
            state_nxt.enableTwo[`PIE_BIT_CMP_TWO]   = regWrData[`PIE_BIT_CMP_TWO];
            state_nxt.enableTwo[`PIE_BIT_CMP_ONE]   = regWrData[`PIE_BIT_CMP_ONE];
            state_nxt.enableTwo[`PIE_BIT_EE_DONE]   = regWrData[`PIE_BIT_EE_DONE];
            state_nxt.enableTwo[`PIE_BIT_SER1_COLL] = regWrData[`PIE_BIT_SER1_COLL];
            state_nxt.enableTwo[`PIE_BIT_CAP_TWO]   = regWrData[`PIE_BIT_CAP_TWO];
        end
        // Registers three and four exist only in the larger variant
        if (wrThree && LARGE_VARIANT) begin
            state_nxt.enableThree[`PIE_BIT_CAP_FOUR]  = regWrData[`PIE_BIT_CAP_FOUR];
            state_nxt.enableThree[`PIE_BIT_CAP_THREE] = regWrData[`PIE_BIT_CAP_THREE];
            state_nxt.enableThree[`PIE_BIT_TMR_SIX]   = regWrData[`PIE_BIT_TMR_SIX];
            state_nxt.enableThree[`PIE_BIT_TMR_FOUR]  = regWrData[`PIE_BIT_TMR_FOUR];
        end
        if (wrFour && LARGE_VARIANT) begin
            state_nxt.enableFour[`PIE_BIT_SER2_COLL]  = regWrData[`PIE_BIT_SER2_COLL];
            state_nxt.enableFour[`PIE_BIT_SER2_EVENT] = regWrData[`PIE_BIT_SER2_EVENT];
        end
        // Register two flags
        state_nxt.flagTwo   = flag_next(state_r.flagTwo, evtTwo, `PIE_MASK_TWO,
                                        wrFlagTwo, regWrData);
        // Register three flags, absent in the smaller variant
        state_nxt.flagThree = flag_next(state_r.flagThree, evtThree, MASK_THREE,
                                        wrFlagThree, regWrData);
        // Register four flags, absent in the smaller variant
        state_nxt.flagFour  = flag_next(state_r.flagFour, evtFour, MASK_FOUR,
                                        wrFlagFour, regWrData);
        // Read data, one cycle after the strobe, zero otherwise
        state_nxt.rdData = 8'h00;
        if (rdSelEnTwo) begin
            state_nxt.rdData = state_r.enableTwo;
        end
        if (rdSelEnThree) begin
            state_nxt.rdData = state_r.enableThree;
        end
        if (rdSelEnFour) begin
            state_nxt.rdData = state_r.enableFour;
        end
        if (rdSelFlagTwo) begin
            state_nxt.rdData = state_r.flagTwo;
        end
        if (rdSelFlagThree) begin
            state_nxt.rdData = state_r.flagThree;
        end
        if (rdSelFlagFour) begin
            state_nxt.rdData = state_r.flagFour;
        end
        if (rdSelStatus) begin
            state_nxt.rdData = {7'h00, state_r.irqReq};
        end
        // Request toward the core
        state_nxt.irqReq = globalPeripheralIrqGate &&
            (oscFailReq ||
             cmpTwoReq ||
             cmpOneReq ||
             eeDoneReq ||
             serOneCollReq ||
             capTwoReq ||
             capFourReq ||
             capThreeReq ||
             tmrSixReq ||
             tmrFourReq ||
             serTwoCollReq ||
             serTwoEvtReq);
    end

    // State register with clock enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    assign regRdData  = state_r.rdData;
    assign irqRequest = state_r.irqReq;

endmodule : pie_enable_bank

`default_nettype wire

// *** design/pie_defs.svh ***
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

// Register indices on the plain register port
`define PIE_ADDR_W           4
`define PIE_IDX_ENABLE_TWO   4'h2
`define PIE_IDX_ENABLE_THREE 4'h3
`define PIE_IDX_ENABLE_FOUR  4'h4
`define PIE_IDX_FLAG_TWO     4'h6
`define PIE_IDX_FLAG_THREE   4'h7
`define PIE_IDX_FLAG_FOUR    4'h8
`define PIE_IDX_STATUS       4'h9

// Implemented-bit masks, unimplemented bits read zero
`define PIE_MASK_TWO         8'hF9
`define PIE_MASK_THREE       8'h3A
`define PIE_MASK_FOUR        8'h03

// Reset values of all enables and flags
`define PIE_RESET_VAL        8'h00

// Field positions in enable/flag register two
`define PIE_BIT_OSC_FAIL     7
`define PIE_BIT_CMP_TWO      6
`define PIE_BIT_CMP_ONE      5
`define PIE_BIT_EE_DONE      4
`define PIE_BIT_SER1_COLL    3
`define PIE_BIT_CAP_TWO      0
// Field positions in register three
`define PIE_BIT_CAP_FOUR     5
`define PIE_BIT_CAP_THREE    4
`define PIE_BIT_TMR_SIX      3
`define PIE_BIT_TMR_FOUR     1
// Field positions in register four
`define PIE_BIT_SER2_COLL    1
`define PIE_BIT_SER2_EVENT   0

`endif

// *** design/pie_pkg.sv ***
package pie_pkg;

    typedef logic [7:0] pie_byte_type;

    // Whole state of the enable bank
    typedef struct packed {
        pie_byte_type enableTwo;
        pie_byte_type enableThree;
        pie_byte_type enableFour;
        pie_byte_type flagTwo;
        pie_byte_type flagThree;
        pie_byte_type flagFour;
        pie_byte_type rdData;
        logic         irqReq;
    } pie_state_type;

endpackage : pie_pkg

// *** test/pie_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pie_src_model (
    input wire logic        clk,
    input wire logic [23:0] req,
    output logic     [7:0]  eventTwo, eventThree, eventFour
);
    // One-cycle event pulses, one edge after request
    always_ff @(posedge clk) begin
        {eventFour, eventThree, eventTwo} <= req;
    end
endmodule : pie_src_model
`default_nettype wire

// *** test/pie_enable_bank_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module pie_enable_bank_asserts (
    input wire logic       clk, rst_n, clkEn, regWrStb, regRdStb,
    input wire logic       globalPeripheralIrqGate, irqRequest,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData, regRdData, eventTwo, eventThree, eventFour
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Implemented bits per register index
    function automatic logic [7:0] m(input logic [3:0] a);
        return (a == 4'h2) ? 8'hF9 : (a == 4'h3) ? 8'h3A : 8'h03;
    endfunction : m
    // Request, gate and register relations
    property p_gate; clkEn && !globalPeripheralIrqGate |=> !irqRequest; endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_rise; $rose(irqRequest) |-> $past(globalPeripheralIrqGate); endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_hold; irqRequest && clkEn && globalPeripheralIrqGate && !regWrStb
        && !$past(regWrStb) |=> irqRequest; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rw; clkEn && regWrStb && regAddr inside {[4'h2:4'h4]} ##1 clkEn && regRdStb
        && $stable(regAddr) |=> regRdData == ($past(regWrData, 2) & m($past(regAddr)));
    endproperty
    a_rw: assert property (p_rw) else $error("readback");
    property p_unimp; clkEn && regRdStb && regAddr inside {[4'h2:4'h4]}
        |=> (regRdData & ~m($past(regAddr))) == 8'h00; endproperty
    a_unimp: assert property (p_unimp) else $error("unimp");
    property p_idle; clkEn && !regRdStb |=> regRdData == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_flag; clkEn && eventTwo[7] && !regWrStb ##1 clkEn && regRdStb
        && regAddr == 4'h6 |=> regRdData[7]; endproperty
    a_flag: assert property (p_flag) else $error("flag two");
    property p_ev4; clkEn && eventFour[0] && !regWrStb ##1 clkEn && regRdStb
        && regAddr == 4'h8 |=> regRdData[0]; endproperty
    a_ev4: assert property (p_ev4) else $error("flag four");
    property p_freeze; !clkEn |=> $stable(regRdData) && $stable(irqRequest); endproperty
    a_freeze: assert property (p_freeze) else $error("freeze");
endmodule : pie_enable_bank_asserts
bind pie_enable_bank pie_enable_bank_asserts CHK (.*);
`default_nettype wire

// *** test/pie_enable_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pie_enable_bank_bench;
    logic        clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
    logic        globalPeripheralIrqGate = 1'b0, irqRequest;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00, regRdData, eventTwo, eventThree, eventFour;
    logic [23:0] req = 24'h00_0000;
    logic [7:0]  msk [3] = '{8'hF9, 8'h3A, 8'h03};
    int          fails = 0, tests_run = 0;
    always #5 clk = ~clk;
    pie_enable_bank DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .globalPeripheralIrqGate(globalPeripheralIrqGate),
        .eventTwo(eventTwo), .eventThree(eventThree), .eventFour(eventFour),
        .irqRequest(irqRequest));
    pie_src_model SRC (.clk(clk), .req(req), .eventTwo(eventTwo),
        .eventThree(eventThree), .eventFour(eventFour));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        #1;
    endtask : wr
    // Read strobe, data compared in the next cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask : rd
    task automatic conclude;
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // Readback, reset, then each source through its enable and the gate
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        for (int r = 0; r < 3; r++) begin
            wr(4'(r + 2), 8'hFF);
            rd(4'(r + 2), msk[r]);
        end
        rd(4'hF, 8'h00);
        rst_n <= 1'b0;
        #10;
        rst_n <= 1'b1;
        rd(4'h3, 8'h00);
        for (int b = 0; b < 24; b++) begin
            if (msk[b / 8][b % 8]) begin
                wr(4'(b / 8 + 2), 8'(1 << (b % 8)));
                req <= 24'h00_0001 << b;
                @(posedge clk);
                req <= 24'h00_0000;
                @(posedge clk);
                #1;
                rd(4'(b / 8 + 6), 8'(1 << (b % 8)));
                chk({7'h00, irqRequest}, 8'h00);
                globalPeripheralIrqGate <= 1'b1;
                repeat (2) @(posedge clk);
                #1;
                chk({7'h00, irqRequest}, 8'h01);
                wr(4'(b / 8 + 2), 8'h00);
                @(posedge clk);
                #1;
                chk({7'h00, irqRequest}, 8'h00);
                wr(4'(b / 8 + 6), 8'h00);
                globalPeripheralIrqGate <= 1'b0;
            end
        end
        clkEn <= 1'b0;
        wr(4'h2, 8'hFF);
        clkEn <= 1'b1;
        rd(4'h2, 8'h00);
        conclude();
    end
endmodule : pie_enable_bank_bench
`default_nettype wire
